// ==== verif/dcc_converter_control_properties.sv ====
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
module dcc_converter_control_properties (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_passive_diode_enable,
  input wire logic i_adc_clock_invert,
  input wire logic o_sfr_sel,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_bypass_ctrl_enable,
  input wire logic o_passive_diode_path,
  input wire logic [1:0] o_min_pulse_width_sel,
  input wire logic [4:0] o_min_pulse_cycles,
  input wire logic o_switch_size_sel,
  input wire logic o_adc_sync_enable,
  input wire logic o_adc_track_enable,
  input wire logic o_adc_track_start,
  input wire logic o_adc_sar_clk_invert,
  input wire logic [2:0] o_output_voltage_sel,
  input wire logic [11:0] o_vout_target_mv
);
  localparam logic [11:0] MV [8] = '{12'h708, 12'h76c, 12'h7d0, 12'h834, 12'h960, 12'ha8c,
    12'hbb8, 12'hce4};
  localparam logic [4:0] PW [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_track_rise;
    $rose(o_adc_track_enable) && o_adc_sync_enable && $past(o_adc_sync_enable);
  endsequence
  sequence s_one_pulse;
    o_adc_track_start ##1 !o_adc_track_start;
  endsequence
  chk_bypass_path: assert property ({o_bypass_ctrl_enable, o_passive_diode_path} ==
    {!$past(i_passive_diode_enable), $past(i_passive_diode_enable)}) else $error("bypass wrong");
  chk_pulse_cycles: assert property (o_min_pulse_cycles == PW[$past(o_min_pulse_width_sel)])
    else $error("pulse cycles wrong");
  chk_vout_table: assert property (o_vout_target_mv == MV[$past(o_output_voltage_sel)])
    else $error("vout wrong");
  chk_write_fields: assert property (i_sfr_wr && o_sfr_sel |=>
    {o_min_pulse_width_sel, o_switch_size_sel, o_adc_sync_enable, o_output_voltage_sel} ==
    {$past(i_sfr_wdata[7:5]), $past(i_sfr_wdata[3:0])}) else $error("write lost");
  chk_read_back: assert property (i_sfr_rd && o_sfr_sel |=>
    {o_sfr_rdata[7:5], o_sfr_rdata[3:0]} == $past({o_min_pulse_width_sel, o_switch_size_sel,
    o_adc_sync_enable, o_output_voltage_sel})) else $error("read data wrong");
  chk_unmapped_read: assert property (i_sfr_rd && !o_sfr_sel |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_sar_invert: assert property (o_adc_sar_clk_invert ==
    ($past(o_adc_sync_enable) && !$past(i_adc_clock_invert))) else $error("sar invert wrong");
  chk_track_pulse: assert property (s_track_rise |-> s_one_pulse)
    else $error("track start pulse wrong");
endmodule : dcc_converter_control_properties

// ==== verif/tb_dcc_converter_control.sv ====
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb_dcc_converter_control;
  logic i_ref_clk = 0, i_arst_n = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_switch_quiet = 0;
  logic i_passive_diode_enable = 0, i_adc_clock_invert = 1;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_page = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
  logic o_sfr_sel, o_bypass_ctrl_enable, o_passive_diode_path, o_switch_size_sel;
  logic o_adc_sync_enable, o_adc_track_enable, o_adc_track_start, o_adc_sar_clk_align;
  logic o_adc_sar_clk_invert;
  logic [1:0] o_min_pulse_width_sel;
  logic [4:0] o_min_pulse_cycles;
  logic [2:0] o_output_voltage_sel;
  logic [11:0] o_vout_target_mv;
  int miscompares = 0, num_checks = 0;
  localparam logic [11:0] MV [8] = '{12'h708, 12'h76c, 12'h7d0, 12'h834, 12'h960, 12'ha8c,
    12'hbb8, 12'hce4};
  localparam logic [4:0] PW [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
  dcc_converter_control u_dut (.*);
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1;
    tick(1);
    i_sfr_wr = 0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [7:0] v);
    i_sfr_addr = a;
    i_sfr_rd = 1;
    tick(1);
    i_sfr_rd = 0;
    v = o_sfr_rdata;
  endtask : rd_reg
  task chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    logic [7:0] v, e;
    int n;
    repeat (12) @(posedge i_ref_clk);
    #1 i_arst_n = 1;
    tick(3);
    rd_reg(8'h97, v);
    chk(v, 8'h21, "reset value");
    chk(o_vout_target_mv, 12'h76c, "reset vout");
    chk(o_bypass_ctrl_enable, 1'b1, "reset bypass");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      e = {i[1:0], ~i[0], 1'b0, i[2], i[2:0]};
      wr_reg(8'h97, e);
      rd_reg(8'h97, v);
      chk(v, e, "readback");
      chk(o_min_pulse_cycles, PW[i % 4], "pulse cycles");
      chk(o_vout_target_mv, MV[i], "vout");
      chk(o_switch_size_sel, !i[0], "switch size");
    end
    $display("test fields done");
    tick(1);
    rd_reg(8'h96, v);
    chk(v, 8'h00, "unmapped read");
    wr_reg(8'h96, 8'h00);
    rd_reg(8'h97, v);
    chk(v, 8'hcf, "unmapped write");
    $display("test decode done");
    i_passive_diode_enable = 1;
    tick(2);
    chk(o_bypass_ctrl_enable, 1'b0, "bypass off");
    chk(o_passive_diode_path, 1'b1, "diode path");
    i_passive_diode_enable = 0;
    $display("test passive done");
    wr_reg(8'h97, 8'h28);
    i_adc_clock_invert = 0;
    tick(8);
    chk(o_adc_sar_clk_invert, 1'b1, "sar invert");
    chk(o_adc_track_enable, 1'b0, "track held");
    chk(o_adc_sar_clk_align, 1'b1, "sar align");
    chk(o_adc_sync_enable, 1'b1, "sync on");
    i_switch_quiet = 1;
    for (n = 0; n < 20 && o_adc_track_start !== 1'b1; n++)
      tick(1);
    chk(o_adc_track_start, 1'b1, "track start");
    if (n == 20)
      finish_test();
    tick(1);
    chk(o_adc_track_start, 1'b0, "track start end");
    i_switch_quiet = 0;
    wr_reg(8'h97, 8'h21);
    tick(8);
    chk(o_adc_sar_clk_invert, 1'b0, "sar invert off");
    chk(o_adc_track_enable, 1'b1, "track free");
    chk(o_adc_sar_clk_align, 1'b0, "sar align off");
    i_switch_quiet = 1;
    for (n = 0; n < 8 && o_adc_track_start !== 1'b1; n++)
      tick(1);
    chk(o_adc_track_start, 1'b0, "no start unsynced");
    chk(o_adc_track_enable, 1'b1, "track still free");
    $display("test adc done");
    finish_test();
  end
endmodule : tb_dcc_converter_control
bind dcc_converter_control dcc_converter_control_properties u_props (.*);

// ==== verilog/dcc_converter_control.sv ====
// converter control register and derived converter controls
`timescale 1ns/1ps
module dcc_converter_control
  import dcc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_passive_diode_enable,
  input wire logic i_adc_clock_invert,
  input wire logic i_switch_quiet,
  output logic o_sfr_sel,
  output logic [7:0] o_sfr_rdata,
  output logic o_bypass_ctrl_enable,
  output logic o_passive_diode_path,
  output logic [1:0] o_min_pulse_width_sel,
  output logic [4:0] o_min_pulse_cycles,
  output logic o_switch_size_sel,
  output logic o_adc_sync_enable,
  output logic o_adc_track_enable,
  output logic o_adc_track_start,
  output logic o_adc_sar_clk_align,
  output logic o_adc_sar_clk_invert,
  output logic [2:0] o_output_voltage_sel,
  output logic [11:0] o_vout_target_mv
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    dcc_trk_type trk;
    logic track_start;
    logic bypass_en;
    logic passive;
    logic [4:0] pw_cycles;
    logic track_en;
    logic sar_inv;
    logic [11:0] vout_mv;
  } dcc_state_type;

  dcc_state_type state;
  dcc_state_type next_state;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic quiet;
  logic hit;

  // decoded strobes and fields
  logic wr_hit;
  logic rd_strobe;
  logic [1:0] pw_code;
  logic [2:0] output_voltage_sel_code;
  logic sync_on;

  // reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_pipe <= 2'b00;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  dcc_sync3 u_quiet_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_async(i_switch_quiet),
    .o_level(quiet)
  );

  // minimum pulse width in clock cycles
  function automatic logic [4:0] pw_to_cycles(input logic [1:0] code);
    logic [4:0] cyc;
    case (dcc_pw_type'(code))
      DCC_PW_NONE: cyc = 5'h00;
      DCC_PW_20: cyc = MIN_PW_20_CYC;
      DCC_PW_40: cyc = MIN_PW_40_CYC;
      DCC_PW_80: cyc = MIN_PW_80_CYC;
      default: cyc = 5'h00;
    endcase
    return cyc;
  endfunction : pw_to_cycles

  // target voltage in millivolts
  function automatic logic [11:0] output_voltage_sel_to_mv(input logic [2:0] code);
    logic [11:0] mv;
    case (code)
      3'h0: mv = VOUT_MV_0;
      3'h1: mv = VOUT_MV_1;
      3'h2: mv = VOUT_MV_2;
      3'h3: mv = VOUT_MV_3;
      3'h4: mv = VOUT_MV_4;
      3'h5: mv = VOUT_MV_5;
      3'h6: mv = VOUT_MV_6;
      3'h7: mv = VOUT_MV_7;
      default: mv = VOUT_MV_0;
    endcase
    return mv;
  endfunction : output_voltage_sel_to_mv

  // register decode at one address on one page
  assign hit = (i_sfr_addr == CTRL_ADDR) && (i_sfr_page == CTRL_PAGE);
  assign wr_hit = hit && i_sfr_wr;
  assign rd_strobe = i_sfr_rd;

  // fields of the stored control byte
  assign pw_code = state.ctrl[MIN_PULSE_WIDTH_SEL_LSB +: 2];
  assign output_voltage_sel_code = state.ctrl[OUTPUT_VOLTAGE_SEL_LSB +: 3];
  assign sync_on = state.ctrl[SYNC_BIT];

  always_comb
  begin
    next_state = state;
    next_state.track_start = 1'b0;

    // whole byte stored, reserved bit included, so reads match writes
    if (wr_hit)
    begin
      next_state.ctrl = i_sfr_wdata;
    end

    // read data latched, unmapped reads give zero
    if (rd_strobe)
    begin
      next_state.rdata = hit ? state.ctrl : 8'h00;
    end

    // bypass-switch controls off in passive-diode mode
    next_state.bypass_en = !i_passive_diode_enable;
    next_state.passive = i_passive_diode_enable;

    // derived converter settings
    next_state.pw_cycles = pw_to_cycles(pw_code);
    next_state.vout_mv = output_voltage_sel_to_mv(output_voltage_sel_code);

    // tracking follows quiet interval only under sync
    if (sync_on)
    begin
      next_state.track_en = quiet;
      case (state.trk)
        DCC_TRK_WAIT:
        begin
          if (quiet)
          begin
            next_state.trk = DCC_TRK_QUIET;
            next_state.track_start = 1'b1;
          end
        end
        DCC_TRK_QUIET:
        begin
          if (!quiet)
          begin
            next_state.trk = DCC_TRK_WAIT;
          end
        end
        default:
        begin
          next_state.trk = DCC_TRK_WAIT;
        end
      endcase
      // invert setting 0 means inverted
      next_state.sar_inv = !i_adc_clock_invert;
    end
    else
    begin
      next_state.track_en = 1'b1;
      next_state.trk = DCC_TRK_WAIT;
      next_state.sar_inv = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state.ctrl <= CTRL_RESET;
      state.rdata <= 8'h00;
      state.trk <= DCC_TRK_WAIT;
      state.track_start <= 1'b0;
      state.bypass_en <= 1'b1;
      state.passive <= 1'b0;
      state.pw_cycles <= 5'h00;
      state.track_en <= 1'b1;
      state.sar_inv <= 1'b0;
      state.vout_mv <= VOUT_MV_1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // bus side
  assign o_sfr_sel = hit;
  assign o_sfr_rdata = state.rdata;

  // power stage controls
  assign o_bypass_ctrl_enable = state.bypass_en;
  assign o_passive_diode_path = state.passive;

  // converter settings
  assign o_min_pulse_width_sel = state.ctrl[MIN_PULSE_WIDTH_SEL_LSB +: 2];
  assign o_min_pulse_cycles = state.pw_cycles;
  assign o_switch_size_sel = state.ctrl[SWSIZE_BIT];
  assign o_output_voltage_sel = state.ctrl[OUTPUT_VOLTAGE_SEL_LSB +: 3];
  assign o_vout_target_mv = state.vout_mv;

  // adc side
  assign o_adc_sync_enable = state.ctrl[SYNC_BIT];
  assign o_adc_track_enable = state.track_en;
  assign o_adc_track_start = state.track_start;
  assign o_adc_sar_clk_align = state.ctrl[SYNC_BIT];
  assign o_adc_sar_clk_invert = state.sar_inv;

endmodule : dcc_converter_control

// ==== verilog/dcc_pkg.sv ====
// constants and types for the dc-dc converter control block
package dcc_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam logic [7:0] CTRL_ADDR = 8'h97;
  localparam logic [7:0] CTRL_PAGE = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h21;

  localparam int MIN_PULSE_WIDTH_SEL_LSB = 6;
  localparam int SWSIZE_BIT = 5;
  localparam int RSVD_BIT = 4;
  localparam int SYNC_BIT = 3;
  localparam int OUTPUT_VOLTAGE_SEL_LSB = 0;

  localparam int MIN_PW_20_NS = 20;
  localparam int MIN_PW_40_NS = 40;
  localparam int MIN_PW_80_NS = 80;
  localparam logic [4:0] MIN_PW_20_CYC = 5'((MIN_PW_20_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] MIN_PW_40_CYC = 5'((MIN_PW_40_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] MIN_PW_80_CYC = 5'((MIN_PW_80_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [11:0] VOUT_MV_0 = 12'd1800;
  localparam logic [11:0] VOUT_MV_1 = 12'd1900;
  localparam logic [11:0] VOUT_MV_2 = 12'd2000;
  localparam logic [11:0] VOUT_MV_3 = 12'd2100;
  localparam logic [11:0] VOUT_MV_4 = 12'd2400;
  localparam logic [11:0] VOUT_MV_5 = 12'd2700;
  localparam logic [11:0] VOUT_MV_6 = 12'd3000;
  localparam logic [11:0] VOUT_MV_7 = 12'd3300;

  typedef enum logic [1:0] {
    DCC_PW_NONE = 2'b00,
    DCC_PW_20 = 2'b01,
    DCC_PW_40 = 2'b10,
    DCC_PW_80 = 2'b11
  } dcc_pw_type;

  typedef enum logic [0:0] {
    DCC_TRK_WAIT = 1'b0,
    DCC_TRK_QUIET = 1'b1
  } dcc_trk_type;

endpackage : dcc_pkg

// ==== verilog/dcc_sync3.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dcc_sync3
  import dcc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } dcc_sync_type;

  dcc_sync_type state;
  dcc_sync_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.s1 = i_async;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    // change counts once stages two and three agree
    if (state.s2 == state.s3)
    begin
      next_state.level = state.s3;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_level = state.level;

endmodule : dcc_sync3
